/* File: ppg_assertions.sv */
`timescale 1ns/1ps
module ppg_assertions (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // side inputs
  input wire sync_in,
  input wire seq_in,
  input wire enable_in,
  input wire interlock_en,
  input wire trip_n,
  // outputs
  input wire pwm_output_a,
  input wire pwm_output_a_oe,
  input wire pwm_output_b,
  input wire pwm_output_b_oe,
  input wire sync_out,
  input wire adc_trig,
  input wire task_trig
);
  reg [13:0] ctrl_reg;
  reg [4:0] calm_reg;
  reg [3:0] held_reg;
  wire calm = &calm_reg;
  wire forced = ctrl_reg[6] & ~enable_in | ctrl_reg[7] & ~trip_n;
  wire act_a = pwm_output_a_oe & (pwm_output_a == ctrl_reg[3]);
  wire act_b = pwm_output_b_oe & (pwm_output_b == ctrl_reg[3]);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // control shadow; pins trail it by a few stages, so wait before judging
  always @(posedge core_clk) begin
    if (reset || reg_wr && reg_addr == 8'h00) calm_reg <= 5'h00;
    else if (!calm) calm_reg <= calm_reg + 5'h01;
    if (reset) ctrl_reg <= 14'h0003;
    else if (reg_wr && reg_addr == 8'h00) ctrl_reg <= reg_wdata[13:0];
  end
  // cycles a forcing cause has stood, past the input synchroniser
  always @(posedge core_clk) begin
    if (reset || !forced) held_reg <= 4'h0;
    else if (held_reg != 4'hc) held_reg <= held_reg + 4'h1;
  end
  sequence s_bad_rd;
    reg_rd && (reg_addr > 8'h20 || reg_addr[1:0] != 2'h0);
  endsequence
  // a sawtooth puts overflow and underflow on adjacent cycles, so judge symmetric only
  sequence s_trig_twice;
    (adc_trig ##1 adc_trig) or (task_trig ##1 task_trig);
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (s_bad_rd |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_comp_no_overlap: assert property (calm && ctrl_reg[1:0] == 2'h0 |-> !(act_a && act_b))
    else $error("both switches on in complementary mode");
  a_off_release: assert property (calm && ctrl_reg[1:0] == 2'h3 |-> !pwm_output_a_oe && !pwm_output_b_oe)
    else $error("pin driven while outputs disabled");
  a_single_b_free: assert property (calm && ctrl_reg[1:0] == 2'h1 |-> !pwm_output_b_oe)
    else $error("b driven in single mode");
  a_forced_passive: assert property (held_reg == 4'hc |-> !act_a && !act_b)
    else $error("output active while forced");
  a_trip_float: assert property (held_reg == 4'hc && ctrl_reg[12] && ctrl_reg[7] && !trip_n |-> !pwm_output_a_oe && !pwm_output_b_oe)
    else $error("pin driven in floating safe state");
  a_trig_single: assert property (calm && ctrl_reg[2] |-> not s_trig_twice)
    else $error("trigger pulse longer than one cycle");
  a_sync_quiet: assert property (calm && !ctrl_reg[9] |-> !sync_out)
    else $error("sync pulse while sync output off");
endmodule
bind ppg_pwm_pair ppg_assertions ppg_assertions_inst (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_in(sync_in),
  .seq_in(seq_in), .enable_in(enable_in), .interlock_en(interlock_en), .trip_n(trip_n),
  .pwm_output_a(pwm_output_a), .pwm_output_a_oe(pwm_output_a_oe),
  .pwm_output_b(pwm_output_b), .pwm_output_b_oe(pwm_output_b_oe),
  .sync_out(sync_out), .adc_trig(adc_trig), .task_trig(task_trig)
);

/* File: ppg_consts.vh */
`ifndef PPG_CONSTS_VH
`define PPG_CONSTS_VH
// register byte offsets
`define PPG_OFS_CTRL 8'h00
`define PPG_OFS_PERIOD 8'h04
`define PPG_OFS_MIDX_A 8'h08
`define PPG_OFS_MIDX_B 8'h0c
`define PPG_OFS_PHASE 8'h10
`define PPG_OFS_DELAY 8'h14
`define PPG_OFS_MINDLY 8'h18
`define PPG_OFS_TRIG 8'h1c
`define PPG_OFS_STATUS 8'h20
// ctrl field positions
`define PPG_CTRL_MODE_LO 0
`define PPG_CTRL_SYM 2
`define PPG_CTRL_POL 3
`define PPG_CTRL_SEQ_NEG 4
`define PPG_CTRL_SEQ_VAR 5
`define PPG_CTRL_EN_PORT 6
`define PPG_CTRL_PROT 7
`define PPG_CTRL_SYNC_EXT 8
`define PPG_CTRL_SYNC_OUT_EN 9
`define PPG_CTRL_VAR_BLANK 10
`define PPG_CTRL_TRIP_OS 11
`define PPG_CTRL_SAFE_FLOAT 12
`define PPG_CTRL_RUN 13
// trig field positions
`define PPG_TRIG_ADC_SEL_LO 0
`define PPG_TRIG_TASK_SEL_LO 2
`define PPG_TRIG_ADC_DIV_LO 4
`define PPG_TRIG_TASK_DIV_LO 8
// output modes
`define PPG_MODE_COMP 2'h0
`define PPG_MODE_SINGLE 2'h1
`define PPG_MODE_DUAL 2'h2
`define PPG_MODE_OFF 2'h3
// event selects
`define PPG_EV_UNDER 2'h1
`define PPG_EV_OVER 2'h2
`define PPG_EV_BOTH 2'h3
// reset values and minimum period
`define PPG_RST_CTRL 16'h0003
`define PPG_RST_PERIOD 16'h03e8
`define PPG_RST_MINDLY 8'h02
`define PPG_MIN_PERIOD 16'h0002
// carrier frequency and period derivation
`define PPG_CLK_HZ 25000000
`define PPG_CARRIER_HZ 25000
`define PPG_PERIOD_CYC (`PPG_CLK_HZ / `PPG_CARRIER_HZ)
`endif

/* File: ppg_gate_model.sv */
`timescale 1ns/1ps
module ppg_gate_model (
  // bench control
  input wire core_clk,
  input wire clr,
  input wire pol,
  input wire fault,
  // gate inputs
  input wire pwm_output_a,
  input wire pwm_output_a_oe,
  input wire pwm_output_b,
  input wire pwm_output_b_oe,
  // trip line and on-time counts
  output wire trip_n,
  output reg [15:0] on_a,
  output reg [15:0] on_b,
  output reg ovl
);
  // a released pin never turns a switch on, whatever the level it floats to
  wire ga = pwm_output_a_oe & (pwm_output_a == pol);
  wire gb = pwm_output_b_oe & (pwm_output_b == pol);
  // desaturation fault pulls the shared trip line low
  assign trip_n = ~fault;
  // count on-time per switch and flag shoot-through
  always @(posedge core_clk) begin
    if (clr) begin
      on_a <= 16'h0000;
      on_b <= 16'h0000;
      ovl <= 1'b0;
    end else begin
      on_a <= on_a + {15'h0000, ga};
      on_b <= on_b + {15'h0000, gb};
      if (ga & gb) ovl <= 1'b1;
    end
  end
endmodule

/* File: ppg_pwm_pair.v */
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "ppg_consts.vh"

// Function
// - carrier runs from zero to full scale, each sequence starting at zero
// - carrier shape is selectable: sawtooth or symmetrical up-down
// - adc and task triggers select underflow, overflow or both independently
// - carrier minimum is underflow, maximum is overflow
// - each trigger fires after its own configurable count of events
// - phase offsets are period fractions, applied on the external sync impulse only
// - complementary mode drives inverse a and b with blanking between edges
// - single mode modulates a only and releases b
// - dual mode modulates a and b from separate indices
// - disabled mode releases both pins; a and b levels still follow the compare
// - blanking separates pair edges, or delays turn-on for single output
// - variable blanking takes one rising/falling delay pair
// - variable blanking never below configured minimum delay
// - a is active when index exceeds carrier; polarity selects level
// - outside dual mode, b is complement of a with respect to polarity
// - positive sequence starts a active, negative starts it passive
// - variable sequence: positive while sequence input above zero
// - enable input at zero forces channels passive
// - protection linkage lets the interlock disable the outputs
// - selectable sync source and optional sync output
// - on trip, outputs go forced passive or high impedance
// - cycle-by-cycle trip holds until underflow, releases if trip gone
// - one-shot trip latches until interlock cycles disabled to enabled
module ppg_pwm_pair (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // pins and side inputs
  input wire sync_in,
  input wire seq_in,
  input wire enable_in,
  input wire interlock_en,
  input wire trip_n,
  // outputs
  output reg pwm_output_a,
  output reg pwm_output_a_oe,
  output reg pwm_output_b,
  output reg pwm_output_b_oe,
  output reg sync_out,
  output reg adc_trig,
  output reg task_trig
);

  // software-visible configuration
  reg [15:0] ctrl_reg;
  reg [15:0] period_reg;
  reg [15:0] midx_a_reg;
  reg [15:0] midx_b_reg;
  reg [15:0] phase_reg;
  reg [15:0] edge_delay_input_reg;
  reg [7:0] mindly_reg;
  reg [11:0] trig_reg;
  // carrier and trigger dividers
  reg [15:0] cnt_reg;
  reg dir_down_reg;
  reg [3:0] adc_cnt_reg;
  reg [3:0] task_cnt_reg;
  // protection latches
  reg trip_cbc_reg;
  reg trip_os_reg;
  reg il_prev_reg;
  // two-stage synchronisers for the pins
  reg [1:0] sync_sr_reg;
  reg sync_prev_reg;
  reg [1:0] trip_sr_reg;
  reg [1:0] seq_sr_reg;
  reg [1:0] en_sr_reg;
  reg [1:0] il_sr_reg;
  // compare-to-pin pipeline
  reg raw_a_reg;
  reg raw_b_reg;
  reg [7:0] dly_a_reg;
  reg [7:0] dly_b_reg;
  reg a_q_reg;
  reg b_q_reg;

  // control and trigger fields
  wire [1:0] mode = ctrl_reg[`PPG_CTRL_MODE_LO+1:`PPG_CTRL_MODE_LO];
  wire sym = ctrl_reg[`PPG_CTRL_SYM];
  wire pol = ctrl_reg[`PPG_CTRL_POL];
  wire run = ctrl_reg[`PPG_CTRL_RUN];
  wire [1:0] adc_sel = trig_reg[`PPG_TRIG_ADC_SEL_LO+1:`PPG_TRIG_ADC_SEL_LO];
  wire [1:0] task_sel = trig_reg[`PPG_TRIG_TASK_SEL_LO+1:`PPG_TRIG_TASK_SEL_LO];
  wire [3:0] adc_div = trig_reg[`PPG_TRIG_ADC_DIV_LO+3:`PPG_TRIG_ADC_DIV_LO];
  wire [3:0] task_div = trig_reg[`PPG_TRIG_TASK_DIV_LO+3:`PPG_TRIG_TASK_DIV_LO];
  wire [15:0] per_m1 = period_reg - 16'h0001;
  wire trip_now = ~trip_sr_reg[1];
  wire sync_edge = sync_sr_reg[1] & ~sync_prev_reg;

  // carrier events: minimum is underflow, maximum overflow
  wire at_zero = (cnt_reg == 16'h0000);
  wire at_top = sym ? (cnt_reg == period_reg) : (cnt_reg == per_m1);
  wire ev_under = run & at_zero;
  wire ev_over = run & at_top;
  // self sync uses master zero count, else the synchronised external edge
  wire sync_hit = ctrl_reg[`PPG_CTRL_SYNC_EXT] ? sync_edge : ev_under;

  // sequence: variable follows input level, else fixed from control
  wire seq_neg = ctrl_reg[`PPG_CTRL_SEQ_VAR] ? ~seq_sr_reg[1] : ctrl_reg[`PPG_CTRL_SEQ_NEG];

  // blanking: rise in [7:0], fall in [15:8], clamped to minimum when variable
  wire [7:0] d_rise_in = edge_delay_input_reg[7:0];
  wire [7:0] d_fall_in = edge_delay_input_reg[15:8];
  wire var_blank = ctrl_reg[`PPG_CTRL_VAR_BLANK];
  wire [7:0] d_rise = (var_blank && d_rise_in < mindly_reg) ? mindly_reg : d_rise_in;
  wire [7:0] d_fall = (var_blank && d_fall_in < mindly_reg) ? mindly_reg : d_fall_in;

  // gating conditions forcing the passive state
  wire en_ok = ~ctrl_reg[`PPG_CTRL_EN_PORT] | en_sr_reg[1];
  wire prot_ok = ~ctrl_reg[`PPG_CTRL_PROT] | (il_sr_reg[1] & ~trip_cbc_reg & ~trip_os_reg);
  wire drive_ok = run & en_ok & prot_ok;
  wire tripped = ctrl_reg[`PPG_CTRL_PROT] & (trip_cbc_reg | trip_os_reg);

  // compare: active when index exceeds carrier; sawtooth carrier scaled by 2
  wire [16:0] cmp_c = sym ? {1'b0, cnt_reg} : {cnt_reg, 1'b0};
  wire act_a = ({1'b0, midx_a_reg} > cmp_c) ^ seq_neg;
  wire act_b = ({1'b0, midx_b_reg} > cmp_c) ^ seq_neg;

  // input synchronisers, first stage feeds only second
  always @(posedge core_clk) begin
    if (reset) begin
      sync_sr_reg <= 2'h0;
      trip_sr_reg <= 2'h3;
      seq_sr_reg <= 2'h0;
      en_sr_reg <= 2'h0;
      il_sr_reg <= 2'h0;
      sync_prev_reg <= 1'b0;
    end else begin
      sync_sr_reg <= {sync_sr_reg[0], sync_in};
      trip_sr_reg <= {trip_sr_reg[0], trip_n};
      seq_sr_reg <= {seq_sr_reg[0], seq_in};
      en_sr_reg <= {en_sr_reg[0], enable_in};
      il_sr_reg <= {il_sr_reg[0], interlock_en};
      sync_prev_reg <= sync_sr_reg[1];
    end
  end

  // register writes
  always @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg <= `PPG_RST_CTRL;
      period_reg <= `PPG_RST_PERIOD;
      midx_a_reg <= 16'h0000;
      midx_b_reg <= 16'h0000;
      phase_reg <= 16'h0000;
      edge_delay_input_reg <= 16'h0000;
      mindly_reg <= `PPG_RST_MINDLY;
      trig_reg <= 12'h000;
    end else if (reg_wr) begin
      if (reg_addr == `PPG_OFS_CTRL) begin
        ctrl_reg <= reg_wdata[15:0];
      end else if (reg_addr == `PPG_OFS_PERIOD) begin
        // a shorter period leaves no room for distinct underflow and overflow
        period_reg <= (reg_wdata[15:0] < `PPG_MIN_PERIOD) ? `PPG_MIN_PERIOD : reg_wdata[15:0];
      end else if (reg_addr == `PPG_OFS_MIDX_A) begin
        midx_a_reg <= reg_wdata[15:0];
      end else if (reg_addr == `PPG_OFS_MIDX_B) begin
        midx_b_reg <= reg_wdata[15:0];
      end else if (reg_addr == `PPG_OFS_PHASE) begin
        phase_reg <= reg_wdata[15:0];
      end else if (reg_addr == `PPG_OFS_DELAY) begin
        edge_delay_input_reg <= reg_wdata[15:0];
      end else if (reg_addr == `PPG_OFS_MINDLY) begin
        mindly_reg <= reg_wdata[7:0];
      end else if (reg_addr == `PPG_OFS_TRIG) begin
        trig_reg <= reg_wdata[11:0];
      end
    end
  end

  // register reads, data one cycle after the strobe; unmapped reads zero
  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == `PPG_OFS_CTRL) begin
        reg_rdata <= {16'h0000, ctrl_reg};
      end else if (reg_addr == `PPG_OFS_PERIOD) begin
        reg_rdata <= {16'h0000, period_reg};
      end else if (reg_addr == `PPG_OFS_MIDX_A) begin
        reg_rdata <= {16'h0000, midx_a_reg};
      end else if (reg_addr == `PPG_OFS_MIDX_B) begin
        reg_rdata <= {16'h0000, midx_b_reg};
      end else if (reg_addr == `PPG_OFS_PHASE) begin
        reg_rdata <= {16'h0000, phase_reg};
      end else if (reg_addr == `PPG_OFS_DELAY) begin
        reg_rdata <= {16'h0000, edge_delay_input_reg};
      end else if (reg_addr == `PPG_OFS_MINDLY) begin
        reg_rdata <= {24'h000000, mindly_reg};
      end else if (reg_addr == `PPG_OFS_TRIG) begin
        reg_rdata <= {20'h00000, trig_reg};
      end else if (reg_addr == `PPG_OFS_STATUS) begin
        // status packs trip latches, direction and count above three zero bits
        reg_rdata <= {10'h000, trip_os_reg, trip_cbc_reg, dir_down_reg, cnt_reg, 3'h0};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // carrier counter; phase is loaded on the external sync edge only, so offsets track that edge
  always @(posedge core_clk) begin
    if (reset || !run) begin
      cnt_reg <= 16'h0000;
      dir_down_reg <= 1'b0;
    end else if (ctrl_reg[`PPG_CTRL_SYNC_EXT] && sync_edge) begin
      cnt_reg <= (phase_reg > per_m1) ? per_m1 : phase_reg;
      dir_down_reg <= 1'b0;
    end else if (sym) begin
      // up-down: zero is underflow, period is overflow
      if (!dir_down_reg) begin
        if (cnt_reg >= period_reg) begin
          dir_down_reg <= 1'b1;
          cnt_reg <= cnt_reg - 16'h0001;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end else if (cnt_reg == 16'h0000) begin
        dir_down_reg <= 1'b0;
        cnt_reg <= 16'h0001;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end else if (cnt_reg >= per_m1) begin
      // sawtooth wraps to zero after period minus one
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // trigger dividers: count qualifying events, pulse on the event that finds the count at the divider
  wire adc_q = (adc_sel[0] & ev_under) | (adc_sel[1] & ev_over);
  wire task_q = (task_sel[0] & ev_under) | (task_sel[1] & ev_over);
  always @(posedge core_clk) begin
    if (reset) begin
      adc_cnt_reg <= 4'h0;
      task_cnt_reg <= 4'h0;
      adc_trig <= 1'b0;
      task_trig <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      adc_trig <= 1'b0;
      task_trig <= 1'b0;
      sync_out <= ctrl_reg[`PPG_CTRL_SYNC_OUT_EN] & sync_hit;
      // a count at or above the divider fires at once, so a lowered divider never stalls
      if (adc_q) begin
        if (adc_cnt_reg >= adc_div) begin
          adc_cnt_reg <= 4'h0;
          adc_trig <= 1'b1;
        end else begin
          adc_cnt_reg <= adc_cnt_reg + 4'h1;
        end
      end
      if (task_q) begin
        if (task_cnt_reg >= task_div) begin
          task_cnt_reg <= 4'h0;
          task_trig <= 1'b1;
        end else begin
          task_cnt_reg <= task_cnt_reg + 4'h1;
        end
      end
    end
  end

  // trip handling; new trips win over any release in the same cycle
  always @(posedge core_clk) begin
    if (reset) begin
      trip_cbc_reg <= 1'b0;
      trip_os_reg <= 1'b0;
      il_prev_reg <= 1'b0;
    end else begin
      il_prev_reg <= il_sr_reg[1];
      // one-shot trips clear only on a fresh interlock enable edge
      if (trip_now && ctrl_reg[`PPG_CTRL_TRIP_OS]) begin
        trip_os_reg <= 1'b1;
      end else if (il_sr_reg[1] && !il_prev_reg) begin
        trip_os_reg <= 1'b0;
      end
      // cycle-by-cycle trips retry once per carrier, at underflow only
      if (trip_now && !ctrl_reg[`PPG_CTRL_TRIP_OS]) begin
        trip_cbc_reg <= 1'b1;
      end else if (ev_under) begin
        trip_cbc_reg <= 1'b0;
      end
    end
  end

  // raw a/b per mode before blanking
  always @(posedge core_clk) begin
    if (reset) begin
      raw_a_reg <= 1'b0;
      raw_b_reg <= 1'b0;
    end else begin
      raw_a_reg <= drive_ok & act_a;
      // single and complementary derive b from a; only dual uses its own index
      if (mode == `PPG_MODE_DUAL) begin
        raw_b_reg <= drive_ok & act_b;
      end else begin
        raw_b_reg <= drive_ok & ~act_a;
      end
    end
  end

  // edge delays: an output turns on only after its delay, off at once
  always @(posedge core_clk) begin
    if (reset) begin
      dly_a_reg <= 8'h00;
      dly_b_reg <= 8'h00;
      a_q_reg <= 1'b0;
      b_q_reg <= 1'b0;
    end else begin
      // turning off at once keeps a complementary pair from ever overlapping
      if (!raw_a_reg) begin
        dly_a_reg <= 8'h00;
        a_q_reg <= 1'b0;
      end else if (dly_a_reg >= d_rise) begin
        a_q_reg <= 1'b1;
      end else begin
        dly_a_reg <= dly_a_reg + 8'h01;
      end
      if (!raw_b_reg) begin
        dly_b_reg <= 8'h00;
        b_q_reg <= 1'b0;
      end else if (dly_b_reg >= d_fall) begin
        b_q_reg <= 1'b1;
      end else begin
        dly_b_reg <= dly_b_reg + 8'h01;
      end
    end
  end

  // pin drive: polarity, mode release and safe state
  always @(posedge core_clk) begin
    if (reset) begin
      pwm_output_a <= 1'b0;
      pwm_output_b <= 1'b0;
      pwm_output_a_oe <= 1'b0;
      pwm_output_b_oe <= 1'b0;
    end else begin
      pwm_output_a <= a_q_reg ? pol : ~pol;
      pwm_output_b <= b_q_reg ? pol : ~pol;
      // release has priority: a disabled channel never drives, tripped or not
      if (mode == `PPG_MODE_OFF) begin
        pwm_output_a_oe <= 1'b0;
        pwm_output_b_oe <= 1'b0;
      end else if (tripped && ctrl_reg[`PPG_CTRL_SAFE_FLOAT]) begin
        pwm_output_a_oe <= 1'b0;
        pwm_output_b_oe <= 1'b0;
      end else begin
        pwm_output_a_oe <= 1'b1;
        pwm_output_b_oe <= (mode != `PPG_MODE_SINGLE);
      end
    end
  end

endmodule

/* File: tb_ppg_pwm_pair.sv */
`timescale 1ns/1ps
`include "ppg_consts.vh"
module tb_ppg_pwm_pair;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0, reg_rd = 1'b0, seq_in = 1'b0, enable_in = 1'b1, interlock_en = 1'b0;
  reg fault = 1'b0, clr = 1'b1, pol = 1'b0, sync_in = 1'b0;
  reg [15:0] n_adc, n_task, n_sync;
  reg [31:0] rng = 32'h7ea4;
  integer fail_count = 0, cmp_count = 0, i, p, s, d, m, w;
  wire [31:0] reg_rdata;
  wire [15:0] on_a, on_b;
  wire trip_n, ovl, out_a, out_a_oe, out_b, out_b_oe, adc_trig, task_trig, sync_out;
  // 25 MHz system clock
  always #20 core_clk = ~core_clk;
  ppg_pwm_pair ppg_pwm_pair_inst (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_in(sync_in), .seq_in(seq_in), .enable_in(enable_in), .interlock_en(interlock_en),
    .trip_n(trip_n), .pwm_output_a(out_a), .pwm_output_a_oe(out_a_oe), .pwm_output_b(out_b),
    .pwm_output_b_oe(out_b_oe), .sync_out(sync_out), .adc_trig(adc_trig),
    .task_trig(task_trig));
  ppg_gate_model ppg_gate_model_inst (.core_clk(core_clk), .clr(clr), .pol(pol),
    .fault(fault), .pwm_output_a(out_a), .pwm_output_a_oe(out_a_oe), .pwm_output_b(out_b),
    .pwm_output_b_oe(out_b_oe), .trip_n(trip_n), .on_a(on_a), .on_b(on_b), .ovl(ovl));
  // trigger pulses counted over a measuring window
  always @(posedge core_clk) begin
    n_adc <= clr ? 16'h0000 : n_adc + {15'h0000, adc_trig};
    n_task <= clr ? 16'h0000 : n_task + {15'h0000, task_trig};
    n_sync <= clr ? 16'h0000 : n_sync + {15'h0000, sync_out};
  end
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  // active cycles per carrier period; sawtooth compares index against twice the count
  function integer eon(input integer mi, input integer pp, input integer sy);
    begin
      if (sy) eon = (mi == 0) ? 0 : (mi > pp) ? 2 * pp : 2 * mi - 1;
      else eon = ((mi + 1) / 2 > pp) ? pp : (mi + 1) / 2;
    end
  endfunction
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
    end
  endtask
  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] ad, input [31:0] v);
    begin
      reg_addr <= ad;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
    end
  endtask
  // answer stands only in the cycle after the strobe, so look there
  task rdc(input [7:0] ad, input [31:0] mk, input [31:0] e);
    begin
      reg_addr <= ad;
      reg_rd <= 1'b1;
      tick(1);
      reg_rd <= 1'b0;
      #1 chk("rdata", e, reg_rdata & mk);
      tick(1);
    end
  endtask
  task go(input [31:0] c, input integer pp, input integer ma, input integer mb);
    begin
      pol <= c[3];
      wr(`PPG_OFS_CTRL, c | 32'h2000);
      wr(`PPG_OFS_PERIOD, pp);
      wr(`PPG_OFS_MIDX_A, ma);
      wr(`PPG_OFS_MIDX_B, mb);
      tick(100);
    end
  endtask
  task meas(input integer n);
    begin
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(n);
      #1;
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // the whole run needs about 4000 cycles
  initial begin
    tick(40000);
    fail_count = fail_count + 1;
    $display("Error watchdog expected done seen hang");
    results;
  end
  initial begin
    tick(12);
    reset <= 1'b0;
    interlock_en <= 1'b1;
    tick(1);
    rdc(`PPG_OFS_CTRL, ~0, `PPG_RST_CTRL);
    rdc(`PPG_OFS_PERIOD, ~0, `PPG_RST_PERIOD);
    rdc(`PPG_OFS_MINDLY, ~0, `PPG_RST_MINDLY);
    wr(8'h24, 32'hffff);
    rdc(8'h24, ~0, 0);
    wr(`PPG_OFS_PERIOD, 1);
    rdc(`PPG_OFS_PERIOD, ~0, 2);
    $display("test registers done");
    wr(`PPG_OFS_DELAY, 0);
    for (i = 0; i < 8; i = i + 1) begin
      rng = xs(rng);
      p = 8 + rng[3:0];
      s = i % 2;
      go(`PPG_MODE_DUAL + 4 * s + 8 * rng[5], p, i < 2 ? 0 : rng[23:8] % (2 * p + 2),
        i < 2 ? 3 * p : rng[31:16] % (2 * p + 2));
      meas(4 * p * (s + 1));
      chk("on_a", 4 * eon(i < 2 ? 0 : rng[23:8] % (2 * p + 2), p, s), on_a);
      chk("on_b", 4 * eon(i < 2 ? 3 * p : rng[31:16] % (2 * p + 2), p, s), on_b);
    end
    $display("test duty done");
    wr(`PPG_OFS_TRIG, `PPG_EV_UNDER);
    for (i = 0; i < 3; i = i + 1) begin
      seq_in <= (i == 2);
      go(`PPG_MODE_DUAL + (i ? 32 : 16) + 8, 20, 20, 0);
      #1 w = 0;
      while (adc_trig !== 1'b1 && w < 100) begin
        tick(1);
        #1 w = w + 1;
      end
      tick(5);
      #1 chk("pin_a", i == 2, out_a);
    end
    $display("test sequence done");
    for (i = 0; i < 3; i = i + 1) begin
      rng = xs(rng);
      d = 1 + rng[1:0];
      m = 1 + rng[3:2];
      wr(`PPG_OFS_MINDLY, 4);
      wr(`PPG_OFS_DELAY, m * 256 + d);
      go(`PPG_MODE_SINGLE * (i == 2) + 1024 * (i == 1) + 8, 20, 20, 0);
      meas(80);
      chk("on_a", 40 - 4 * (i == 1 ? 4 : d), on_a);
      chk("on_b", i == 2 ? 0 : 40 - 4 * (i == 1 ? 4 : m), on_b);
      chk("overlap", 0, ovl);
    end
    $display("test blanking done");
    // symmetric carrier of five keeps the ten-cycle carrier period
    go(`PPG_MODE_DUAL + 4 + 512, 5, 10, 10);
    for (i = 1; i < 4; i = i + 1) begin
      rng = xs(rng);
      d = rng[1:0];
      wr(`PPG_OFS_TRIG, i + 4 * (4 - i) + 16 * d + 256 * d);
      tick(40);
      meas(20 * (d + 1));
      chk("adc", 2 * (i % 2 + i / 2), n_adc);
      chk("task", 2 * ((4 - i) % 2 + (4 - i) / 2), n_task);
      chk("sync", 2 * (d + 1), n_sync);
    end
    // external sync loads the phase count and echoes one sync pulse
    wr(`PPG_OFS_PHASE, 4);
    go(`PPG_MODE_DUAL + 256 + 512, 10, 10, 10);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    sync_in <= 1'b1;
    tick(1);
    sync_in <= 1'b0;
    tick(2);
    rdc(`PPG_OFS_STATUS, 32'h7fff8, 32'h20);
    #1 chk("sync", 1, n_sync);
    $display("test triggers done");
    enable_in <= 1'b0;
    go(`PPG_MODE_COMP + 64, 10, 10, 0);
    meas(40);
    chk("on_a", 0, on_a);
    chk("on_b", 0, on_b);
    enable_in <= 1'b1;
    $display("test enable done");
    go(`PPG_MODE_DUAL + 128, 10, 20, 20);
    fault <= 1'b1;
    tick(10);
    meas(40);
    chk("on_a", 0, on_a);
    fault <= 1'b0;
    tick(40);
    meas(40);
    chk("on_a", 40, on_a);
    go(`PPG_MODE_DUAL + 128 + 2048, 10, 20, 20);
    fault <= 1'b1;
    tick(4);
    fault <= 1'b0;
    tick(40);
    meas(40);
    chk("on_a", 0, on_a);
    rdc(`PPG_OFS_STATUS, 32'h200000, 32'h200000);
    interlock_en <= 1'b0;
    tick(4);
    interlock_en <= 1'b1;
    tick(40);
    meas(40);
    chk("on_a", 40, on_a);
    go(`PPG_MODE_DUAL + 128 + 4096, 10, 20, 20);
    fault <= 1'b1;
    tick(20);
    #1 chk("a_oe", 0, out_a_oe);
    $display("test trips done");
    results;
  end
endmodule
